// ==== include/reconfig_pkg.sv ====
// Shared constants for the reconfiguration controller and its register-streaming host.
package reconfig_pkg;
  // Link register indices of the reconfiguration controller.
  localparam logic [6:0] RB_CHANNEL = 7'h08;
  localparam logic [6:0] RB_CONTROL = 7'h0a;
  localparam logic [6:0] RB_OFFSET = 7'h0b;
  localparam logic [6:0] RB_DATA = 7'h0c;
  localparam logic [6:0] ST_CHANNEL = 7'h38;
  localparam logic [6:0] ST_CONTROL = 7'h3a;
  localparam logic [6:0] ST_OFFSET = 7'h3b;
  localparam logic [6:0] ST_DATA = 7'h3c;
  // Control and status field positions.
  localparam int CTL_WRITE_BIT = 0;
  localparam int CTL_READ_BIT = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_BUSY_BIT = 8;
  // Register-based launch codes.
  localparam logic [31:0] RB_LAUNCH_WRITE = 32'h0000_0001;
  localparam logic [31:0] RB_LAUNCH_READ = 32'h0000_0002;
  // Feature offsets.
  localparam logic [31:0] FEAT_OUTPUT_SWING = 32'h0000_0000;
  localparam logic [31:0] FEAT_PRETAP = 32'h0000_0001;
  // Stream engine modes and internal offsets.
  localparam logic [1:0] MODE_IMAGE = 2'h0;
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [10:0] IMG_OFF_BASE = 11'h000;
  localparam logic [10:0] IMG_OFF_START = 11'h001;
  localparam logic [31:0] IMG_START_CODE = 32'h0000_0003;
  // Record header layout: length above the starting offset.
  localparam int HDR_OFF_MSB = 10;
  localparam int HDR_LEN_LSB = 11;
  localparam int HDR_LEN_MSB = 15;
  // Configuration word that holds the pattern generator enables.
  localparam logic [10:0] PATTERN_OFFSET = 11'h007;
  // Cycles the controller takes to apply a register-based write or read.
  localparam int APPLY_NS = 32;
  localparam int CLOCK_NS = 8;
  localparam int APPLY_CYCLES = (APPLY_NS + CLOCK_NS - 1) / CLOCK_NS;
  // Host APB register byte addresses.
  localparam logic [7:0] HA_ADDR = 8'h00;
  localparam logic [7:0] HA_WRITE = 8'h04;
  localparam logic [7:0] HA_READ = 8'h08;
  localparam logic [7:0] HA_STATUS = 8'h0c;
  localparam logic [7:0] HA_RDATA = 8'h10;
  // Host command word: write flag, link address, data.
  localparam int CMD_W = 40;
endpackage

// ==== include/reconfig_if.sv ====
// Register link between the streaming host and the reconfiguration controller.
`timescale 1ns/10ps
interface reconfig_if;
  logic req; // Host request, held until ack.
  logic wr; // One for a write, zero for a read.
  logic [6:0] addr; // Register index.
  logic [31:0] wdata; // Write data.
  logic ack; // One-cycle answer pulse.
  logic [31:0] rdata; // Read data, valid with ack.
  modport device (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

// ==== hdl/cmd_fifo.sv ====
// Parameterised valid/ready FIFO for host commands.
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [AW-1:0] wptr; // Next slot to fill.
  logic [AW-1:0] rptr; // Oldest word.
  logic [AW:0] count; // Words held.
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset; only words that count covers are ever read.
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== hdl/reconfig_controller.sv ====
// Reconfiguration controller: register-based settings and stream engine.
// Behaviour
// - Host waits for busy bit 8 clear.
// - Host loads channel, offset, data, then write.
// - Busy holds until channel has new value.
// - Host loads channel, offset, read, polls busy.
// - Completed read leaves setting in data register.
// - Control 0x1 launches write, 0x2 read.
// - Offset 0 swing, offset 1 pre-tap.
// - Mode 2'b01 selects direct record writes.
// - Host writes offset, data, write per record; offset stays put.
// - Stream busy spans whole operation exactly.
// - Header holds length and offset bits 10:0.
// - Control 0x4 selects mode 1, 0x5 commits.
// - Mode 2'b00 selects image streaming.
// - Image: offset 0, base as data, write.
// - Offset 1, data 0x3, write starts stream.
// - Image words fetched from ROM, applied.
// - Host polls busy between stream accesses.
// - Pattern generator enables are settable.
`timescale 1ns/10ps
module reconfig_controller #(
  parameter int NCH = 4,
  parameter int CFG_AW = 3,
  parameter int IMG_AW = 9
) (
  input wire logic clock,
  input wire logic nrst,
  reconfig_if.device link,
  output logic [NCH*3-1:0] pattern_enable,
  output logic [NCH*16-1:0] output_swing
);
  localparam int CW = $clog2(NCH);
  typedef enum logic [2:0] {st_idle, st_header, st_record} stream_state_e;

  // Register-based front end.
  logic [31:0] rb_channel; // Selected logical channel.
  logic [31:0] rb_offset; // Selected feature.
  logic [31:0] rb_data; // Data to write or data fetched.
  logic rb_busy; // Operation in progress.
  logic rb_is_read; // Pending operation is a read.
  logic [7:0] rb_count; // Cycles left until applied.
  logic [15:0] swing [NCH]; // Output swing per channel.
  logic [15:0] pretap [NCH]; // Pre-emphasis pre-tap per channel.

  // Stream engine.
  logic [31:0] st_channel; // Target channel.
  logic [1:0] st_mode; // Direct or image mode.
  logic [10:0] st_offset; // Internal offset.
  logic [31:0] st_data; // Record data or fetched value.
  logic [IMG_AW-1:0] img_base; // Registered image base.
  logic [IMG_AW-1:0] img_ptr; // Next image word.
  logic [10:0] rec_off; // Offset of the next record word.
  logic [4:0] rec_left; // Data records left under the header.
  stream_state_e st_state;
  logic [15:0] cfg [NCH][2**CFG_AW]; // Channel configuration space.

  logic take; // A new link request is taken this edge.
  logic ctl_wr; // Register write taken from the link, to any address.
  logic [CW-1:0] rb_ch; // Channel index, cut to the channel count.
  logic [CW-1:0] st_ch;
  logic [CFG_AW-1:0] st_idx; // Configuration word index.
  logic [15:0] img_now; // Image word under the pointer.
  logic st_busy;

  assign take = link.req && !link.ack;
  assign rb_ch = rb_channel[CW-1:0];
  assign st_ch = st_channel[CW-1:0];
  assign st_idx = st_offset[CFG_AW-1:0];
  assign img_now = image_word(img_ptr);
  assign st_busy = (st_state != st_idle);

  // Stored settings image; the sample content is arbitrary and ends with an empty header.
  function automatic logic [15:0] image_word(input logic [IMG_AW-1:0] a);
    case (a)
      9'h100: image_word = 16'h1800; // Three records from offset 0.
      9'h101: image_word = 16'h2820;
      9'h102: image_word = 16'h1234;
      9'h103: image_word = 16'h81d4;
      9'h104: image_word = 16'h0807; // One record at the pattern word.
      9'h105: image_word = 16'h0001;
      default: image_word = 16'h0000;
    endcase
  endfunction

  // Status word: busy in bit 8, mode in bits 3:2.
  function automatic logic [31:0] status_word(input logic busy, input logic [1:0] mode);
    status_word = '0;
    status_word[reconfig_pkg::CTL_BUSY_BIT] = busy;
    status_word[reconfig_pkg::CTL_MODE_LSB +: 2] = mode;
  endfunction

  assign ctl_wr = take && link.wr;

  // Link answer one cycle after a request; unmapped reads return zero.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      link.ack <= 1'b0;
      link.rdata <= '0;
    end
    else
    begin
      link.ack <= take;
      if (take && !link.wr)
      begin
        case (link.addr)
          reconfig_pkg::RB_CHANNEL: link.rdata <= rb_channel;
          reconfig_pkg::RB_CONTROL: link.rdata <= status_word(rb_busy, 2'h0);
          reconfig_pkg::RB_OFFSET: link.rdata <= rb_offset;
          reconfig_pkg::RB_DATA: link.rdata <= rb_data;
          reconfig_pkg::ST_CHANNEL: link.rdata <= st_channel;
          reconfig_pkg::ST_CONTROL: link.rdata <= status_word(st_busy, st_mode);
          reconfig_pkg::ST_OFFSET: link.rdata <= 32'(st_offset);
          reconfig_pkg::ST_DATA: link.rdata <= st_data;
          default: link.rdata <= '0;
        endcase
      end
    end
  end

  // Register-based front end; launches while busy are ignored.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rb_channel <= '0;
      rb_offset <= '0;
      rb_data <= '0;
      rb_busy <= 1'b0;
      rb_is_read <= 1'b0;
      rb_count <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        swing[c] <= '0;
        pretap[c] <= '0;
      end
    end
    else if (rb_busy)
    begin
      // The setting lands in the same edge that drops busy.
      if (rb_count == 8'h01)
      begin
        rb_busy <= 1'b0;
        if (rb_is_read)
        begin
          // Fetched value stays until the next read or data write.
          case (rb_offset)
            reconfig_pkg::FEAT_OUTPUT_SWING: rb_data <= 32'(swing[rb_ch]);
            reconfig_pkg::FEAT_PRETAP: rb_data <= 32'(pretap[rb_ch]);
            default: rb_data <= '0;
          endcase
        end
        else
        begin
          case (rb_offset)
            reconfig_pkg::FEAT_OUTPUT_SWING: swing[rb_ch] <= rb_data[15:0];
            reconfig_pkg::FEAT_PRETAP: pretap[rb_ch] <= rb_data[15:0];
            default: ;
          endcase
        end
      end
      rb_count <= rb_count - 8'h01;
    end
    else if (ctl_wr)
    begin
      case (link.addr)
        reconfig_pkg::RB_CHANNEL: rb_channel <= link.wdata;
        reconfig_pkg::RB_OFFSET: rb_offset <= link.wdata;
        reconfig_pkg::RB_DATA: rb_data <= link.wdata;
        reconfig_pkg::RB_CONTROL:
        begin
          // Only the two documented launch codes start an operation.
          if (link.wdata == reconfig_pkg::RB_LAUNCH_WRITE ||
              link.wdata == reconfig_pkg::RB_LAUNCH_READ)
          begin
            rb_busy <= 1'b1;
            rb_is_read <= (link.wdata == reconfig_pkg::RB_LAUNCH_READ);
            rb_count <= 8'(reconfig_pkg::APPLY_CYCLES);
          end
        end
        default: ;
      endcase
    end
  end

  // Stream engine registers, direct records and image streaming.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_channel <= '0;
      st_mode <= reconfig_pkg::MODE_IMAGE;
      st_offset <= '0;
      st_data <= '0;
      img_base <= '0;
      img_ptr <= '0;
      rec_off <= '0;
      rec_left <= '0;
      st_state <= st_idle;
      for (int c = 0; c < NCH; c++)
      begin
        for (int w = 0; w < 2**CFG_AW; w++)
        begin
          cfg[c][w] <= '0;
        end
      end
    end
    else
    begin
      case (st_state)
        st_idle:
        begin
          if (ctl_wr)
          begin
            case (link.addr)
              reconfig_pkg::ST_CHANNEL: st_channel <= link.wdata;
              reconfig_pkg::ST_OFFSET: st_offset <= link.wdata[10:0];
              reconfig_pkg::ST_DATA: st_data <= link.wdata;
              reconfig_pkg::ST_CONTROL:
              begin
                st_mode <= link.wdata[reconfig_pkg::CTL_MODE_LSB +: 2];
                if (link.wdata[reconfig_pkg::CTL_MODE_LSB +: 2] == reconfig_pkg::MODE_DIRECT)
                begin
                  // Direct records: a 0x5 commits, a 0x6 fetches.
                  if (link.wdata[reconfig_pkg::CTL_WRITE_BIT])
                  begin
                    cfg[st_ch][st_idx] <= st_data[15:0];
                  end
                  else if (link.wdata[reconfig_pkg::CTL_READ_BIT])
                  begin
                    st_data <= 32'(cfg[st_ch][st_idx]);
                  end
                end
                else if (link.wdata[reconfig_pkg::CTL_MODE_LSB +: 2] ==
                         reconfig_pkg::MODE_IMAGE && link.wdata[reconfig_pkg::CTL_WRITE_BIT])
                begin
                  if (st_offset == reconfig_pkg::IMG_OFF_BASE)
                  begin
                    img_base <= st_data[IMG_AW-1:0];
                  end
                  else if (st_offset == reconfig_pkg::IMG_OFF_START &&
                           st_data == reconfig_pkg::IMG_START_CODE)
                  begin
                    img_ptr <= img_base;
                    st_state <= st_header;
                  end
                end
              end
              default: ;
            endcase
          end
        end
        st_header:
        begin
          // A header with zero length ends the image and drops busy.
          if (img_now[reconfig_pkg::HDR_LEN_MSB:reconfig_pkg::HDR_LEN_LSB] == 5'h00)
          begin
            st_state <= st_idle;
          end
          else
          begin
            rec_left <= img_now[reconfig_pkg::HDR_LEN_MSB:reconfig_pkg::HDR_LEN_LSB];
            rec_off <= img_now[reconfig_pkg::HDR_OFF_MSB:0];
            img_ptr <= img_ptr + 1'b1;
            st_state <= st_record;
          end
        end
        st_record:
        begin
          // Offsets beyond the configuration space wrap onto it.
          cfg[st_ch][rec_off[CFG_AW-1:0]] <= img_now;
          rec_off <= rec_off + 11'h001;
          rec_left <= rec_left - 5'h01;
          img_ptr <= img_ptr + 1'b1;
          if (rec_left == 5'h01)
          begin
            st_state <= st_header;
          end
        end
        default: st_state <= st_idle;
      endcase
    end
  end

  // Pattern enables and swing come straight from stored flip-flops.
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      pattern_enable[c*3 +: 3] = cfg[c][reconfig_pkg::PATTERN_OFFSET[CFG_AW-1:0]][2:0];
      output_swing[c*16 +: 16] = swing[c];
    end
  end
endmodule

// ==== hdl/reconfig_host.sv ====
// Streaming host: APB command port, command FIFO, busy-polling link master.
`timescale 1ns/10ps
module reconfig_host #(
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  reconfig_if.host link
);
  typedef enum logic [2:0] {h_idle, h_poll, h_poll_wait, h_xfer, h_xfer_wait} host_state_e;

  logic [6:0] cmd_addr; // Link address for the next command.
  logic [31:0] last_rdata; // Data of the latest queued link read; busy polls leave it unchanged.
  logic push; // Command pushed this edge.
  logic [reconfig_pkg::CMD_W-1:0] push_word;
  logic fifo_ready;
  logic fifo_valid;
  logic [reconfig_pkg::CMD_W-1:0] fifo_word;
  logic pop;
  logic access; // APB access phase not yet answered.
  logic done; // Transfer completes at this edge.
  logic is_push_addr;
  logic is_ctl; // Command targets a control register.
  host_state_e state;

  assign access = psel && penable && !pready;
  assign is_push_addr = pwrite && (paddr == reconfig_pkg::HA_WRITE || paddr == reconfig_pkg::HA_READ);
  assign done = psel && penable && pready;
  assign push = done && is_push_addr && fifo_ready;
  assign push_word = {paddr == reconfig_pkg::HA_WRITE, cmd_addr, pwdata};
  assign is_ctl = fifo_word[38:32] == reconfig_pkg::RB_CONTROL ||
                  fifo_word[38:32] == reconfig_pkg::ST_CONTROL;
  assign pop = (state == h_xfer_wait) && link.ack;

  // Command queue; a full queue stalls the APB write.
  cmd_fifo #(.WIDTH(reconfig_pkg::CMD_W), .DEPTH(DEPTH)) queue (
    .clock(clock),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_word)
  );

  // APB slave; pready is registered, so every access lasts two cycles or more.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      cmd_addr <= '0;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (access && (!is_push_addr || fifo_ready))
      begin
        pready <= 1'b1;
        prdata <= '0;
        case (paddr)
          reconfig_pkg::HA_ADDR: prdata <= 32'(cmd_addr);
          reconfig_pkg::HA_WRITE, reconfig_pkg::HA_READ: ;
          reconfig_pkg::HA_STATUS: prdata <= {30'h0, state != h_idle, !fifo_valid};
          reconfig_pkg::HA_RDATA: prdata <= last_rdata;
          default: pslverr <= 1'b1;
        endcase
      end
      // Writes land only at the edge where the master sees pready high.
      if (done && pwrite && paddr == reconfig_pkg::HA_ADDR)
      begin
        cmd_addr <= pwdata[6:0];
      end
    end
  end

  // Link master; control writes first poll busy until it reads clear.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= h_idle;
      link.req <= 1'b0;
      link.wr <= 1'b0;
      link.addr <= '0;
      link.wdata <= '0;
      last_rdata <= '0;
    end
    else
    begin
      case (state)
        h_idle:
        begin
          if (fifo_valid)
          begin
            state <= (fifo_word[39] && is_ctl) ? h_poll : h_xfer;
          end
        end
        h_poll:
        begin
          link.req <= 1'b1;
          link.wr <= 1'b0;
          link.addr <= fifo_word[38:32];
          state <= h_poll_wait;
        end
        h_poll_wait:
        begin
          if (link.ack)
          begin
            link.req <= 1'b0;
            state <= link.rdata[reconfig_pkg::CTL_BUSY_BIT] ? h_poll : h_xfer;
          end
        end
        h_xfer:
        begin
          // Commands leave in queue order, so channel, offset, data precede the launch.
          link.req <= 1'b1;
          link.wr <= fifo_word[39];
          link.addr <= fifo_word[38:32];
          link.wdata <= fifo_word[31:0];
          state <= h_xfer_wait;
        end
        h_xfer_wait:
        begin
          if (link.ack)
          begin
            link.req <= 1'b0;
            if (!link.wr)
            begin
              last_rdata <= link.rdata;
            end
            state <= h_idle;
          end
        end
        default: state <= h_idle;
      endcase
    end
  end
endmodule

// ==== tb/reconfig_link_chk.sv ====
// Link assertions between the streaming host and the reconfiguration controller.
`timescale 1ns/10ps
module reconfig_link_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req,
  input wire logic wr,
  input wire logic [6:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  localparam int AP = reconfig_pkg::APPLY_CYCLES;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Cycles since the last register-based launch; saturates so stale launches fade out.
  logic [7:0] since_launch;
  // Set by a control poll that saw busy clear; any other answer clears it.
  logic polled;
  // Launch age counter, restarted by an accepted write or read launch.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      since_launch <= 8'hff;
    else if (ack && wr && addr == reconfig_pkg::RB_CONTROL && wdata inside {32'h1, 32'h2})
      since_launch <= 8'h00;
    else if (since_launch != 8'hff)
      since_launch <= since_launch + 8'h01;
  end
  // Poll tracker; a write straight after a clear poll is the only safe launch.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      polled <= 1'b0;
    else if (ack)
      polled <= !wr && !rdata[8] &&
        (addr == reconfig_pkg::RB_CONTROL || addr == reconfig_pkg::ST_CONTROL);
  end
  a_ack_follows_req: assert property (req && !ack |=> ack)
    else $error("ack did not follow a taken request");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed before ack");
  a_ack_single: assert property (ack |=> !ack && !req)
    else $error("ack longer than one cycle or request kept");
  a_rdata_on_read: assert property (!$stable(rdata) |-> ack && !wr)
    else $error("read data changed outside a read answer");
  a_unmapped_zero: assert property (ack && !wr && !(addr inside {7'h08, 7'h0a, 7'h0b, 7'h0c,
    7'h38, 7'h3a, 7'h3b, 7'h3c}) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_direct_not_busy: assert property (ack && !wr && addr == reconfig_pkg::ST_CONTROL &&
    rdata[3:2] == reconfig_pkg::MODE_DIRECT |-> !rdata[8])
    else $error("direct mode reported busy");
  a_launch_polled: assert property (req && wr && (addr == reconfig_pkg::RB_CONTROL ||
    addr == reconfig_pkg::ST_CONTROL) |-> polled)
    else $error("control written without a clear poll");
  a_busy_bounded: assert property (ack && !wr && addr == reconfig_pkg::RB_CONTROL && rdata[8]
    |-> since_launch <= AP + 2)
    else $error("busy held too long");
  a_busy_kept: assert property (ack && !wr && addr == reconfig_pkg::RB_CONTROL && !rdata[8]
    |-> since_launch >= AP - 1)
    else $error("busy cleared too early");
endmodule

// ==== tb/xcvr_reconfig_register_streamer_tb.sv ====
// Self-checking bench for the streaming host and controller pair.
`timescale 1ns/10ps
module xcvr_reconfig_register_streamer_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] pattern_enable;
  logic [63:0] output_swing;
  logic [31:0] rd; // Data of the last APB transfer.
  logic err; // Error flag of the last APB transfer.
  int mismatches = 0;
  int n_compared = 0;
  reconfig_if link ();
  reconfig_host u_reconfig_host (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  reconfig_controller u_reconfig_controller (.clock(clock), .nrst(nrst), .link(link),
    .pattern_enable(pattern_enable), .output_swing(output_swing));
  reconfig_link_chk u_reconfig_link_chk (.clock(clock), .nrst(nrst), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 clock = ~clock;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Queues one link write.
  task automatic link_wr(input logic [6:0] idx, input logic [31:0] d);
    apb(1'b1, reconfig_pkg::HA_ADDR, {25'h0, idx});
    apb(1'b1, reconfig_pkg::HA_WRITE, d);
  endtask
  // Waits until the host queue is empty and its engine idle.
  task automatic drain();
    do
      apb(1'b0, reconfig_pkg::HA_STATUS, 32'h0);
    while (rd[1:0] !== 2'b01);
  endtask
  // Link read; the result is left in rd.
  task automatic link_rd(input logic [6:0] idx);
    apb(1'b1, reconfig_pkg::HA_ADDR, {25'h0, idx});
    apb(1'b1, reconfig_pkg::HA_READ, 32'h0);
    drain();
    apb(1'b0, reconfig_pkg::HA_RDATA, 32'h0);
  endtask
  // Polls a control register until busy reads clear; plain writes are dropped while busy.
  task automatic wait_clear(input logic [6:0] idx);
    do
      link_rd(idx);
    while (rd[8] !== 1'b0);
  endtask
  // Register-based swing write, pre-tap write and read-back, unmapped read.
  task automatic t_register();
    link_wr(reconfig_pkg::RB_CHANNEL, 32'h0);
    link_wr(reconfig_pkg::RB_OFFSET, reconfig_pkg::FEAT_OUTPUT_SWING);
    link_wr(reconfig_pkg::RB_DATA, 32'h28);
    link_wr(reconfig_pkg::RB_CONTROL, reconfig_pkg::RB_LAUNCH_WRITE);
    wait_clear(reconfig_pkg::RB_CONTROL);
    chk(32'(output_swing[15:0]), 32'h28);
    link_wr(reconfig_pkg::RB_CHANNEL, 32'h2);
    link_wr(reconfig_pkg::RB_OFFSET, reconfig_pkg::FEAT_PRETAP);
    link_wr(reconfig_pkg::RB_DATA, 32'h15);
    link_wr(reconfig_pkg::RB_CONTROL, reconfig_pkg::RB_LAUNCH_WRITE);
    wait_clear(reconfig_pkg::RB_CONTROL);
    chk(32'(output_swing[47:32]), 32'h0);
    link_wr(reconfig_pkg::RB_DATA, 32'h0);
    link_wr(reconfig_pkg::RB_CONTROL, reconfig_pkg::RB_LAUNCH_READ);
    wait_clear(reconfig_pkg::RB_CONTROL);
    link_rd(reconfig_pkg::RB_DATA);
    chk(rd, 32'h15);
    link_rd(7'h20);
    chk(rd, 32'h0);
    link_rd(reconfig_pkg::RB_DATA);
    chk(rd, 32'h15);
    $display("register test done");
  endtask
  // Direct mode: three records, a pattern enable word and a read-back.
  task automatic t_direct();
    logic [31:0] rec [3] = '{32'h2820, 32'h1234, 32'h81d4};
    link_wr(reconfig_pkg::ST_CHANNEL, 32'h1);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h4);
    for (int i = 0; i < 3; i++)
    begin
      link_wr(reconfig_pkg::ST_OFFSET, 32'(i));
      link_wr(reconfig_pkg::ST_DATA, rec[i]);
      link_wr(reconfig_pkg::ST_CONTROL, 32'h5);
    end
    link_wr(reconfig_pkg::ST_OFFSET, 32'(reconfig_pkg::PATTERN_OFFSET));
    link_wr(reconfig_pkg::ST_DATA, 32'h5);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h5);
    link_rd(reconfig_pkg::ST_CONTROL);
    chk(32'(rd[3:2]), 32'(reconfig_pkg::MODE_DIRECT));
    chk(32'(rd[8]), 32'h0);
    chk(32'(pattern_enable[5:3]), 32'h5);
    link_wr(reconfig_pkg::ST_OFFSET, 32'h1);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h6);
    link_rd(reconfig_pkg::ST_DATA);
    chk(rd, 32'h1234);
    $display("direct test done");
  endtask
  // Image mode: base, start, wait for busy to clear, check applied words.
  task automatic t_image();
    link_wr(reconfig_pkg::ST_CHANNEL, 32'h3);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h0);
    link_wr(reconfig_pkg::ST_OFFSET, 32'(reconfig_pkg::IMG_OFF_BASE));
    link_wr(reconfig_pkg::ST_DATA, 32'h100);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h1);
    link_wr(reconfig_pkg::ST_OFFSET, 32'(reconfig_pkg::IMG_OFF_START));
    link_wr(reconfig_pkg::ST_DATA, reconfig_pkg::IMG_START_CODE);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h1);
    wait_clear(reconfig_pkg::ST_CONTROL);
    chk(32'(pattern_enable[11:9]), 32'h1);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h4);
    link_wr(reconfig_pkg::ST_OFFSET, 32'h2);
    link_wr(reconfig_pkg::ST_CONTROL, 32'h6);
    link_rd(reconfig_pkg::ST_DATA);
    chk(rd, 32'h81d4);
    $display("image test done");
  endtask
  // Host port: burst of queued writes, unmapped address, address read-back.
  task automatic t_apb();
    apb(1'b1, reconfig_pkg::HA_ADDR, 32'h38);
    repeat (12) apb(1'b1, reconfig_pkg::HA_WRITE, 32'h0);
    link_rd(reconfig_pkg::ST_CHANNEL);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, reconfig_pkg::HA_ADDR, 32'h0);
    chk(rd, 32'h38);
    $display("apb test done");
  endtask
  // Hang guard, well past the expected run length.
  initial
  begin
    #320000;
    mismatches++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end
  // Main sequence after 20 cycles of reset.
  initial
  begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_register();
    t_direct();
    t_image();
    t_apb();
    summarize();
  end
endmodule
